/* File: status_word_params.svh */
// Purpose: Named constants for the status word and real-mode control block
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef STATUS_WORD_PARAMS_SVH
`define STATUS_WORD_PARAMS_SVH
`define MSW_RESET 16'hfff0
`define MSW_PE 0
`define MSW_MP 1
`define MSW_EM 2
`define MSW_TS 3
`define MSW_LOW_MASK 16'h000f
`define EXC_COPROC 8'h07
`define EXC_TABLE 8'h08
`define EXC_OVERRUN 8'h09
`define EXC_SEGMENT 8'h0d
`define NMI_VECTOR 8'h02
`define TABLE_BASE_RESET 24'h000000
`define TABLE_LIMIT_RESET 16'h03ff
`define TABLE_LIMIT_NMI_MIN 16'h000f
`define SP_NMI_MIN 16'h0005
`define OFFSET_TOP 16'hffff
`define RESET_ADDR 20'hffff0
`define VEC_SHIFT 2
`define SEG_SHIFT 4
`define MODE_RUN 2'b01
`define MODE_HALT 2'b10
`define MODE_SHUT 2'b11
`endif

/* File: status_word_pkg.sv */
// Purpose: Types for the status word and real-mode control block
// Assumes: Constants come from status_word_params.svh
// Notes: Packed structs carry grouped signals
package status_word_pkg;
  typedef enum logic [2:0] {
    RUN_ST = 3'b001,
    HALT_ST = 3'b010,
    SHUT_ST = 3'b100
  } cpu_state_t;

  typedef struct packed {
    logic load_status;
    logic store_status;
    logic load_table;
    logic stop;
    logic coproc_op;
    logic wait_op;
    logic int_op;
    logic word_access;
    logic exec_past_end;
    logic coproc_mem_over;
    logic stack_wrap;
    logic stack_class;
    logic [7:0] int_vector;
    logic [15:0] operand;
    logic [23:0] table_base;
    logic [15:0] selector;
    logic [15:0] offset;
    logic [15:0] stack_pointer;
    logic [15:0] next_ip;
    logic [15:0] this_ip;
  } insn_t;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic [15:0] return_ip;
    logic state_kept;
  } exc_t;

  typedef struct packed {
    logic cycle;
    logic addr_bit1;
  } halt_cycle_t;
endpackage

/* File: status_word_store.sv */
// Purpose: Holds the two table registers for the vector table
// Assumes: Single clock, asynchronous reset
// Notes: Read data come from registers
`timescale 1ns/1ps
`default_nettype none
`include "status_word_params.svh"
module status_word_store (
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Async reset high
  input wire logic wr_i, // Load table
  input wire logic [23:0] base_i, // New base
  input wire logic [15:0] limit_i, // New limit
  output logic [23:0] base_o, // Table base
  output logic [15:0] limit_o // Table limit
);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      base_o <= `TABLE_BASE_RESET;
      limit_o <= `TABLE_LIMIT_RESET;
    end else if (wr_i) begin
      base_o <= base_i;
      limit_o <= limit_i;
    end
  end
endmodule // status_word_store
`default_nettype wire

/* File: status_word_real_mode_control.sv */
// Purpose: Status word, halt/shutdown and real-mode addressing checks
// Assumes: One instruction strobe per cycle at most; inputs synchronous
// Notes: Outputs are registered one cycle after the strobe
// How it works
// - Status word is 16 bits, low four live, resets to fff0.
// - Protect bit set by load stays set until reset.
// - Monitor bit lets wait instructions raise exception 7.
// - Soft fallback bit makes every coprocessor opcode raise exception 7.
// - Context change flag makes next coprocessor use raise exception 7.
// - Flag plus monitor traps both; all clear traps neither.
// - Load and store status instructions work in real mode.
// - Stop halts and frees bus; only requests or reset resume.
// - Interrupt leaving halt saves the location after the stop.
// - Real mode drives address bits 0 to 19; upper four ignored.
// - Physical address is selector shifted four plus offset.
// - Segments span 64K; wrapping access may fault.
// - Reset start at ffff0; vectors low, top bytes reserved.
// - Interrupt vector beyond table limit raises 8 at the instruction.
// - Coprocessor operand past ffff raises 9, return after instruction.
// - Word at ffff or running past segment end raises 13.
// - Address faults keep prior state except stack push and pop.
// - Table load sets 24-bit base, 16-bit limit; reset 0 and 3ff.
// - Halt cycle announces halt with bit1 high, shutdown low.
// - Exception 8 or 13 outside table limit enters shutdown.
// - Stack wrap with odd pointer enters shutdown.
// - Nonmaskable exits shutdown only if limit>=f and pointer>5.
`timescale 1ns/1ps
`default_nettype none
`include "status_word_params.svh"
module status_word_real_mode_control (
  input wire logic clk_i, // 25 MHz clock
  input wire logic sys_rst_i, // Async reset high
  input wire status_word_pkg::insn_t insn_i, // Decoded instruction info
  input wire logic insn_valid_i, // Instruction strobe
  input wire logic nmi_i, // Nonmaskable request
  input wire logic maskable_request_i, // Maskable request
  input wire logic int_allow_i, // Interrupt-allow flag
  output logic [15:0] machine_status_word_o, // Status word
  output logic [15:0] store_data_o, // Store-status result
  output logic store_valid_o, // Store result pulse
  output status_word_pkg::exc_t exc_o, // Exception report
  output logic [23:0] phys_addr_o, // Physical address, 23:20 zero
  output logic high_byte_enable_o, // High byte lane
  output logic bus_release_o, // Bus released
  output status_word_pkg::halt_cycle_t halt_cycle_o, // Halt bus cycle
  output logic [1:0] mode_o, // 01 run 10 halt 11 shutdown
  output logic [23:0] table_base_o, // Vector table base
  output logic [15:0] table_limit_o, // Vector table limit
  output logic [19:0] start_addr_o // Reset fetch address
);
  import status_word_pkg::*;

  typedef struct packed {
    logic [15:0] machine_status_word;
    cpu_state_t state;
    logic [15:0] store_data;
    logic store_valid;
    exc_t exc;
    logic [19:0] addr;
    logic hbe;
    halt_cycle_t hcycle;
    logic [15:0] halt_ip;
    logic rel;
    logic [1:0] mode;
    logic [19:0] start;
  } state_t;

  state_t cur_reg;
  state_t cur_next;
  logic [23:0] base_w;
  logic [15:0] limit_w;
  logic table_wr;
  logic ev_run_w;

  function automatic logic [19:0] real_addr(input logic [15:0] sel, input logic [15:0] off);
    real_addr = {sel, 4'h0} + {4'h0, off};
  endfunction

  function automatic logic vec_inside(input logic [7:0] vec, input logic [15:0] lim);
    logic [17:0] top;
    top = ({10'h000, vec} << `VEC_SHIFT) + 18'h00003;
    vec_inside = (top <= {2'b00, lim});
  endfunction

  function automatic exc_t make_exc(input logic [7:0] v, input logic [15:0] ip, input logic kept);
    exc_t e;
    e.valid = 1'b1;
    e.vector = v;
    e.return_ip = ip;
    e.state_kept = kept;
    return e;
  endfunction

  assign table_wr = insn_valid_i && insn_i.load_table && (cur_reg.state == RUN_ST);
  assign ev_run_w = insn_valid_i && (cur_reg.state == RUN_ST);

  status_word_store u_store (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_i(table_wr),
    .base_i(insn_i.table_base),
    .limit_i(insn_i.operand),
    .base_o(base_w),
    .limit_o(limit_w)
  );

  always_comb begin
    logic ev_ok;
    logic cop_trap;
    logic wait_trap;
    logic kept;
    ev_ok = 1'b0;
    cop_trap = 1'b0;
    wait_trap = 1'b0;
    kept = 1'b0;
    cur_next = cur_reg;
    cur_next.store_valid = 1'b0;
    cur_next.exc = '0;
    cur_next.hcycle = '0;
    ev_ok = insn_valid_i && (cur_reg.state == RUN_ST);
    kept = !insn_i.stack_class;
    cop_trap = cur_reg.machine_status_word[`MSW_EM] || cur_reg.machine_status_word[`MSW_TS];
    wait_trap = cur_reg.machine_status_word[`MSW_MP] && cur_reg.machine_status_word[`MSW_TS];
    case (cur_reg.state)
      RUN_ST: begin
        if (ev_ok) begin
          cur_next.addr = real_addr(insn_i.selector, insn_i.offset);
          cur_next.hbe = insn_i.word_access || insn_i.offset[0];
          if (insn_i.coproc_op && cop_trap) begin
            cur_next.exc = make_exc(`EXC_COPROC, insn_i.this_ip, 1'b1);
          end else if (insn_i.wait_op && wait_trap) begin
            cur_next.exc = make_exc(`EXC_COPROC, insn_i.this_ip, 1'b1);
          end else if (insn_i.stack_wrap && insn_i.stack_pointer[0]) begin
            cur_next.state = SHUT_ST;
            cur_next.hcycle.cycle = 1'b1;
          end else if (insn_i.int_op && !vec_inside(insn_i.int_vector, limit_w)) begin
            if (vec_inside(`EXC_TABLE, limit_w)) begin
              cur_next.exc = make_exc(`EXC_TABLE, insn_i.this_ip, kept);
            end else begin
              cur_next.state = SHUT_ST;
              cur_next.hcycle.cycle = 1'b1;
            end
          end else if (insn_i.coproc_op && insn_i.coproc_mem_over) begin
            cur_next.exc = make_exc(`EXC_OVERRUN, insn_i.next_ip, kept);
          end else if ((insn_i.word_access && insn_i.offset == `OFFSET_TOP)
                       || insn_i.exec_past_end) begin
            if (vec_inside(`EXC_SEGMENT, limit_w)) begin
              cur_next.exc = make_exc(`EXC_SEGMENT, insn_i.this_ip, kept);
            end else begin
              cur_next.state = SHUT_ST;
              cur_next.hcycle.cycle = 1'b1;
            end
          end else if (insn_i.load_status) begin
            cur_next.machine_status_word = (cur_reg.machine_status_word & ~`MSW_LOW_MASK)
                         | (insn_i.operand & `MSW_LOW_MASK);
            cur_next.machine_status_word[`MSW_PE] = cur_reg.machine_status_word[`MSW_PE] | insn_i.operand[`MSW_PE];
          end else if (insn_i.store_status) begin
            cur_next.store_data = cur_reg.machine_status_word;
            cur_next.store_valid = 1'b1;
          end else if (insn_i.stop) begin
            cur_next.state = HALT_ST;
            cur_next.halt_ip = insn_i.next_ip;
            cur_next.hcycle.cycle = 1'b1;
            cur_next.hcycle.addr_bit1 = 1'b1;
          end
        end
      end
      HALT_ST: begin
        if (nmi_i || (maskable_request_i && int_allow_i)) begin
          cur_next.state = RUN_ST;
          cur_next.exc.valid = nmi_i;
          cur_next.exc.vector = `NMI_VECTOR;
          cur_next.exc.return_ip = cur_reg.halt_ip;
          cur_next.exc.state_kept = 1'b1;
        end
      end
      SHUT_ST: begin
        if (nmi_i && (limit_w >= `TABLE_LIMIT_NMI_MIN)
            && (insn_i.stack_pointer > `SP_NMI_MIN)) begin
          cur_next.state = RUN_ST;
          cur_next.exc = make_exc(`NMI_VECTOR, insn_i.this_ip, 1'b1);
        end
      end
      default: begin
        cur_next.state = RUN_ST;
      end
    endcase
    cur_next.rel = (cur_next.state != RUN_ST);
    cur_next.mode = {cur_next.state != RUN_ST, cur_next.state != HALT_ST};
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cur_reg <= '0;
      cur_reg.machine_status_word <= `MSW_RESET;
      cur_reg.state <= RUN_ST;
      cur_reg.mode <= `MODE_RUN;
      cur_reg.start <= `RESET_ADDR;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign machine_status_word_o = cur_reg.machine_status_word;
  assign store_data_o = cur_reg.store_data;
  assign store_valid_o = cur_reg.store_valid;
  assign exc_o = cur_reg.exc;
  assign phys_addr_o = {4'h0, cur_reg.addr};
  assign high_byte_enable_o = cur_reg.hbe;
  assign bus_release_o = cur_reg.rel;
  assign halt_cycle_o = cur_reg.hcycle;
  assign mode_o = cur_reg.mode;
  assign table_base_o = base_w;
  assign table_limit_o = limit_w;
  assign start_addr_o = cur_reg.start;

  property pe_sticky_p;
    @(posedge clk_i) disable iff (sys_rst_i)
      $past(cur_reg.machine_status_word[`MSW_PE]) |-> cur_reg.machine_status_word[`MSW_PE];
  endproperty
  pe_sticky_a: assert property (pe_sticky_p) else $error("protect bit cleared");

  msw_high_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cur_reg.machine_status_word[15:4] == 12'hfff) else $error("status word high bits changed");

  em_trap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ev_run_w && insn_i.coproc_op && cur_reg.machine_status_word[`MSW_EM])
    |=> (exc_o.valid && exc_o.vector == `EXC_COPROC)) else $error("no trap 7");

  ts_trap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ev_run_w && insn_i.coproc_op && cur_reg.machine_status_word[`MSW_TS])
    |=> (exc_o.valid && exc_o.vector == `EXC_COPROC)) else $error("no trap 7 on flag");

  wait_trap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ev_run_w && insn_i.wait_op && !insn_i.coproc_op && !cur_reg.machine_status_word[`MSW_MP])
    |=> !(exc_o.valid && exc_o.vector == `EXC_COPROC)) else $error("wait trapped");

  both_trap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ev_run_w && insn_i.wait_op && !insn_i.coproc_op && cur_reg.machine_status_word[`MSW_MP]
     && cur_reg.machine_status_word[`MSW_TS])
    |=> (exc_o.valid && exc_o.vector == `EXC_COPROC)) else $error("wait not trapped");

  no_trap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ev_run_w && cur_reg.machine_status_word[`MSW_TS:`MSW_MP] == 3'b000)
    |=> !(exc_o.valid && exc_o.vector == `EXC_COPROC)) else $error("trap with bits clear");

  store_data_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    store_valid_o |-> store_data_o == machine_status_word_o) else $error("bad store data");

  halt_enter_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ev_run_w && insn_i.stop && !insn_i.coproc_op && !insn_i.wait_op && !insn_i.int_op
     && !insn_i.stack_wrap && !insn_i.coproc_mem_over && !insn_i.word_access
     && !insn_i.exec_past_end && !insn_i.load_status && !insn_i.store_status)
    |=> (halt_cycle_o.cycle && halt_cycle_o.addr_bit1 && bus_release_o))
    else $error("halt not announced");

  cycle_kind_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    halt_cycle_o.cycle |-> mode_o == (halt_cycle_o.addr_bit1 ? `MODE_HALT : `MODE_SHUT))
    else $error("halt cycle kind wrong");

  halt_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cur_reg.state == HALT_ST && !nmi_i && !(maskable_request_i && int_allow_i))
    |=> cur_reg.state == HALT_ST) else $error("halt left early");

  halt_wake_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cur_reg.state == HALT_ST && !nmi_i && maskable_request_i && int_allow_i)
    |=> (mode_o == `MODE_RUN && !exc_o.valid)) else $error("halt not left");

  halt_ret_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cur_reg.state == HALT_ST && nmi_i)
    |=> (exc_o.valid && exc_o.return_ip == $past(cur_reg.halt_ip)))
    else $error("wrong halt return");

  ret_table_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (exc_o.valid && exc_o.vector == `EXC_TABLE)
    |-> exc_o.return_ip == $past(insn_i.this_ip)) else $error("bad return for 8");

  ret_overrun_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (exc_o.valid && exc_o.vector == `EXC_OVERRUN)
    |-> exc_o.return_ip == $past(insn_i.next_ip)) else $error("bad return for 9");

  ret_segment_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (exc_o.valid && exc_o.vector == `EXC_SEGMENT)
    |-> exc_o.return_ip == $past(insn_i.this_ip)) else $error("bad return for 13");

  state_kept_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (exc_o.valid && (exc_o.vector == `EXC_TABLE || exc_o.vector == `EXC_OVERRUN
     || exc_o.vector == `EXC_SEGMENT))
    |-> exc_o.state_kept != $past(insn_i.stack_class)) else $error("bad state kept");

  table_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ev_run_w && insn_i.load_table)
    |=> (table_base_o == $past(insn_i.table_base) && table_limit_o == $past(insn_i.operand)))
    else $error("table not loaded");

  stack_shut_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ev_run_w && insn_i.stack_wrap && insn_i.stack_pointer[0] && !insn_i.coproc_op
     && !insn_i.wait_op)
    |=> mode_o == `MODE_SHUT) else $error("odd stack wrap not shut");

  shut_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cur_reg.state == SHUT_ST && limit_w < `TABLE_LIMIT_NMI_MIN)
    |=> cur_reg.state == SHUT_ST) else $error("shutdown left");

  shut_sp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cur_reg.state == SHUT_ST && insn_i.stack_pointer <= `SP_NMI_MIN)
    |=> cur_reg.state == SHUT_ST) else $error("shutdown left on low pointer");

  shut_exit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cur_reg.state == SHUT_ST && nmi_i && limit_w >= `TABLE_LIMIT_NMI_MIN
     && insn_i.stack_pointer > `SP_NMI_MIN)
    |=> (mode_o == `MODE_RUN && exc_o.valid)) else $error("shutdown not left");

  addr_form_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ev_run_w |=> phys_addr_o[19:0] ==
      ($past({insn_i.selector, 4'h0}) + {4'h0, $past(insn_i.offset)}))
    else $error("bad address");

  halt_cov_c: cover property (@(posedge clk_i) cur_reg.state == HALT_ST);
  shut_cov_c: cover property (@(posedge clk_i) cur_reg.state == SHUT_ST);
  exc_cov_c: cover property (@(posedge clk_i) exc_o.valid && exc_o.vector == `EXC_SEGMENT);
  store_cov_c: cover property (@(posedge clk_i) store_valid_o);
  wake_cov_c: cover property (@(posedge clk_i) cur_reg.state == HALT_ST && maskable_request_i
    && int_allow_i);
endmodule // status_word_real_mode_control
`default_nettype wire

/* File: sys_bus_model.sv */
// Purpose: Local bus partner: interrupt request lines and halt cycle log
// Assumes: Requests come from the bench off the sampling edge
// Notes: Records the kind of the last halt bus cycle seen
`timescale 1ns/1ps
`default_nettype none
module sys_bus_model (
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Async reset high
  input wire logic nmi_req_i, // Bench asks for nonmaskable
  input wire logic maskable_request_req_i, // Bench asks for maskable
  input wire status_word_pkg::halt_cycle_t halt_cycle_i, // Halt bus cycle
  output logic nmi_o, // Nonmaskable request line
  output logic maskable_request_o, // Maskable request line
  output logic [1:0] last_kind_o // Seen flag, address bit 1
);
  import status_word_pkg::*;
  assign nmi_o = nmi_req_i;
  assign maskable_request_o = maskable_request_req_i;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_kind_o <= 2'h0;
    end else if (halt_cycle_i.cycle) begin
      last_kind_o <= {1'b1, halt_cycle_i.addr_bit1};
    end
  end
endmodule // sys_bus_model
`default_nettype wire

/* File: status_word_real_mode_control_tb_top.sv */
// Purpose: Self-checking bench for the status word and real-mode block
// Assumes: Inputs change on the falling edge; answers one cycle later
// Notes: One task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "status_word_params.svh"
module status_word_real_mode_control_tb_top;
  import status_word_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  insn_t insn_i = '0;
  insn_t ins = '0;
  logic insn_valid_i = 1'b0;
  logic int_allow_i = 1'b0;
  logic nmi_req = 1'b0;
  logic maskable_request_req = 1'b0;
  logic nmi_w, maskable_request_w, svalid, hbe, rel;
  logic [15:0] machine_status_word, sdata, tlim;
  exc_t exc;
  logic [23:0] pa, tbase;
  halt_cycle_t hc;
  logic [1:0] mode, kind;
  logic [19:0] start;
  int fail_count = 0;
  int cmp_count = 0;
  always #20 clk_i = ~clk_i;
  status_word_real_mode_control status_word_real_mode_control_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .insn_i(insn_i), .insn_valid_i(insn_valid_i), .nmi_i(nmi_w),
    .maskable_request_i(maskable_request_w), .int_allow_i(int_allow_i), .machine_status_word_o(machine_status_word),
    .store_data_o(sdata), .store_valid_o(svalid), .exc_o(exc), .phys_addr_o(pa),
    .high_byte_enable_o(hbe), .bus_release_o(rel), .halt_cycle_o(hc), .mode_o(mode),
    .table_base_o(tbase), .table_limit_o(tlim), .start_addr_o(start));
  sys_bus_model sys_bus_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .nmi_req_i(nmi_req), .maskable_request_req_i(maskable_request_req), .halt_cycle_i(hc), .nmi_o(nmi_w),
    .maskable_request_o(maskable_request_w), .last_kind_o(kind));
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_exc(input logic v, input logic [7:0] vec, input logic [15:0] ip);
    chk("exc valid", {23'h0, v}, {23'h0, exc.valid});
    if (v === 1'b1) begin
      chk("exc vector", {16'h0, vec}, {16'h0, exc.vector});
      chk("exc return", {8'h0, ip}, {8'h0, exc.return_ip});
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic issue();
    @(negedge clk_i);
    insn_i = ins;
    insn_valid_i = 1'b1;
    @(negedge clk_i);
    insn_valid_i = 1'b0;
    ins = '0;
  endtask
  task automatic load_msw(input logic [15:0] op);
    ins.load_status = 1'b1;
    ins.operand = op;
    issue();
  endtask
  // Request held for one cycle by this task; the partner passes it straight through
  task automatic req(input logic nmi);
    @(negedge clk_i);
    if (nmi) begin
      nmi_req = 1'b1;
    end else begin
      maskable_request_req = 1'b1;
    end
    @(negedge clk_i);
    nmi_req = 1'b0;
    maskable_request_req = 1'b0;
  endtask
  task automatic do_reset();
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
  endtask
  task automatic chk_idle();
    chk("status word", {8'h0, `MSW_RESET}, {8'h0, machine_status_word});
    chk("table base", `TABLE_BASE_RESET, tbase);
    chk("table limit", {8'h0, `TABLE_LIMIT_RESET}, {8'h0, tlim});
    chk("mode", 24'h1, {22'h0, mode});
    chk("bus release", 24'h0, {23'h0, rel});
    chk("start addr", {4'h0, `RESET_ADDR}, {4'h0, start});
  endtask
  task automatic t_coproc();
    logic [3:0] low [5] = '{4'h0, 4'h4, 4'hc, 4'h2, 4'ha};
    logic esc_t [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic wt_t [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 5; i++) begin
      load_msw({12'h000, low[i]});
      chk("status word", {8'h0, (`MSW_RESET | {12'h000, low[i]})}, {8'h0, machine_status_word});
      ins.coproc_op = 1'b1;
      ins.this_ip = 16'h0010;
      issue();
      chk_exc(esc_t[i], `EXC_COPROC, 16'h0010);
      ins.wait_op = 1'b1;
      ins.this_ip = 16'h0020;
      issue();
      chk_exc(wt_t[i], `EXC_COPROC, 16'h0020);
    end
    ins.store_status = 1'b1;
    issue();
    chk("store valid", 24'h1, {23'h0, svalid});
    chk("store data", 24'h00fffa, {8'h0, sdata});
    $display("test coproc done");
  endtask
  task automatic t_addr();
    ins.selector = 16'h1234;
    ins.offset = 16'h5679;
    issue();
    chk("phys addr", 24'h0179b9, pa);
    chk("high byte", 24'h1, {23'h0, hbe});
    ins.selector = 16'hffff;
    ins.offset = 16'h0010;
    issue();
    chk("phys addr", 24'h000000, pa);
    chk("high byte", 24'h0, {23'h0, hbe});
    $display("test addr done");
  endtask
  task automatic t_faults();
    load_msw(16'h0000);
    ins.coproc_op = 1'b1;
    ins.coproc_mem_over = 1'b1;
    ins.this_ip = 16'h0030;
    ins.next_ip = 16'h0034;
    issue();
    chk_exc(1'b1, `EXC_OVERRUN, 16'h0034);
    ins.word_access = 1'b1;
    ins.offset = `OFFSET_TOP;
    ins.this_ip = 16'h0040;
    issue();
    chk_exc(1'b1, `EXC_SEGMENT, 16'h0040);
    chk("state kept", 24'h1, {23'h0, exc.state_kept});
    ins.word_access = 1'b1;
    ins.offset = `OFFSET_TOP;
    ins.stack_class = 1'b1;
    issue();
    chk("state kept", 24'h0, {23'h0, exc.state_kept});
    ins.exec_past_end = 1'b1;
    ins.this_ip = 16'h0050;
    issue();
    chk_exc(1'b1, `EXC_SEGMENT, 16'h0050);
    ins.load_table = 1'b1;
    ins.table_base = 24'h123456;
    ins.operand = 16'h0027;
    issue();
    chk("table base", 24'h123456, tbase);
    chk("table limit", 24'h000027, {8'h0, tlim});
    ins.int_op = 1'b1;
    ins.int_vector = 8'h0a;
    ins.this_ip = 16'h0060;
    issue();
    chk_exc(1'b1, `EXC_TABLE, 16'h0060);
    $display("test faults done");
  endtask
  task automatic t_shut();
    ins.load_table = 1'b1;
    ins.operand = 16'h001f;
    issue();
    ins.word_access = 1'b1;
    ins.offset = `OFFSET_TOP;
    issue();
    chk("mode", 24'h3, {22'h0, mode});
    chk("halt cycle", 24'h2, {22'h0, hc.cycle, hc.addr_bit1});
    chk("bus release", 24'h1, {23'h0, rel});
    insn_i.stack_pointer = `SP_NMI_MIN;
    req(1'b1);
    chk("mode", 24'h3, {22'h0, mode});
    chk("partner kind", 24'h2, {22'h0, kind});
    insn_i.stack_pointer = 16'h0006;
    insn_i.this_ip = 16'h0070;
    req(1'b1);
    chk("mode", 24'h1, {22'h0, mode});
    chk_exc(1'b1, `NMI_VECTOR, 16'h0070);
    $display("test shutdown done");
  endtask
  task automatic t_halt();
    ins.stop = 1'b1;
    issue();
    chk("halt cycle", 24'h3, {22'h0, hc.cycle, hc.addr_bit1});
    chk("mode", 24'h2, {22'h0, mode});
    chk("bus release", 24'h1, {23'h0, rel});
    req(1'b0);
    chk("mode", 24'h2, {22'h0, mode});
    int_allow_i = 1'b1;
    req(1'b0);
    chk("mode", 24'h1, {22'h0, mode});
    ins.stop = 1'b1;
    ins.next_ip = 16'h0091;
    issue();
    req(1'b1);
    chk_exc(1'b1, `NMI_VECTOR, 16'h0091);
    $display("test halt done");
  endtask
  task automatic t_prot();
    load_msw(16'h0001);
    chk("status word", 24'h00fff1, {8'h0, machine_status_word});
    load_msw(16'h0000);
    chk("status word", 24'h00fff1, {8'h0, machine_status_word});
    ins.stack_wrap = 1'b1;
    ins.stack_class = 1'b1;
    ins.stack_pointer = 16'h0003;
    issue();
    chk("mode", 24'h3, {22'h0, mode});
    do_reset();
    chk_idle();
    ins.load_table = 1'b1;
    ins.operand = 16'h0007;
    issue();
    ins.int_op = 1'b1;
    ins.int_vector = 8'h0a;
    issue();
    chk("mode", 24'h3, {22'h0, mode});
    insn_i.stack_pointer = 16'h0006;
    req(1'b1);
    chk("mode", 24'h3, {22'h0, mode});
    $display("test protect done");
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    $display("wrong value run length expected done seen timeout");
    close_out();
  end
  initial begin
    do_reset();
    chk_idle();
    t_coproc();
    t_addr();
    t_faults();
    t_shut();
    t_halt();
    t_prot();
    close_out();
  end
endmodule // status_word_real_mode_control_tb_top
`default_nettype wire
